// ==== hdl/spife_core.sv ====
// Serial flash command core: page program, page erase, sector erase and
// deep power-down, with write latch, busy flag and block protection.
// Assumes the SPI pins arrive asynchronously, the block-protect bits come
// from logic on sys_clk_i, and the array answers mem_rdata_i combinationally
// for the address on mem_addr_o.
// Function
// R01: Programming only ANDs new data into the array, never sets bits.
// R02: Program and erase run only with the write latch set.
// R03: Master sends opcode, three address bytes, data bytes, select held low.
// R04: Data past the page end wraps to the page start.
// R05: Over 256 bytes, only the final 256 remain in the page.
// R06: With fewer bytes, untouched page bytes keep their contents.
// R07: Program executes only if select rises on a byte boundary.
// R08: Select rise starts timed program, busy set, write latch cleared.
// R09: Program into a protected page is not executed.
// R10: Page erase writes FFh to every byte of the page.
// R11: Master sends opcode plus three address bytes for page erase.
// R12: Page erase needs exactly four bytes, then timed cycle with busy.
// R13: Page erase into a protected page is not executed.
// R14: Page erase during a running cycle is rejected.
// R15: Sector erase writes FFh to every byte of the sector.
// R16: Sector erase needs exactly four bytes, then timed cycle with busy.
// R17: Sector erase of a sector touching protection is refused.
// R18: Sector erase during a running cycle is rejected.
// R19: Deep power-down ignores write, program and erase commands.
// R20: Deep power-down entered only from standby, not during a cycle.
// R21: Deep power-down needs exactly one byte, active after entry time.
// R22: Deep power-down command during a cycle is rejected.
// R23: In deep power-down only release is obeyed, returning to standby.
// R24: Busy flag is set and cleared by internal logic only.
// R25: Bits latched on serial clock rise, MSB first, 8-bit opcodes.
`timescale 1ns/1ps

module spife_core #(
  parameter int ADDR_W = 24,
  parameter int SECTOR_SIZE = spife_pkg::SECTOR_BYTES,
  parameter int PROG_CYC = spife_pkg::PROG_CYCLES,
  parameter int PERASE_CYC = spife_pkg::PAGE_ERASE_CYCLES,
  parameter int SERASE_CYC = spife_pkg::SECTOR_ERASE_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic chip_select_n_i,
  input wire logic serial_clk_i,
  input wire logic serial_in_i,
  input wire logic protect_bit_hi_i,
  input wire logic protect_bit_lo_i,
  input wire logic [7:0] mem_rdata_i,
  output logic busy_flag_o,
  output logic write_latch_flag_o,
  output logic deep_pd_o,
  output logic mem_we_o,
  output logic [ADDR_W-1:0] mem_addr_o,
  output logic [7:0] mem_wdata_o
);
  import spife_pkg::*;

  localparam logic [ADDR_W-1:0] SEC_MASK = ADDR_W'(SECTOR_SIZE - 1);
  localparam logic [ADDR_W-1:0] PAGE_MASK = ADDR_W'(PAGE_LAST);
  localparam logic [31:0] PROG_LOAD = 32'(PROG_CYC - 1);
  localparam logic [31:0] PERASE_LOAD = 32'(PERASE_CYC - 1);
  localparam logic [31:0] SERASE_LOAD = 32'(SERASE_CYC - 1);
  localparam logic [31:0] DPD_LOAD = DPD_CYCLES - 32'h0000_0001;

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_d;
    logic ck_s1;
    logic ck_s2;
    logic ck_d;
    logic si_s1;
    logic si_s2;
    logic [7:0] shift;
    logic [2:0] bits;
    logic [8:0] nbytes;
    logic [7:0] cmd;
    logic [ADDR_W-1:0] addr;
    logic [7:0] ptr;
    logic [255:0] valid;
    spife_st_t st;
    logic [ADDR_W-1:0] base;
    logic [ADDR_W-1:0] last;
    logic [ADDR_W-1:0] walk;
    logic [31:0] timer;
    logic write_latch_flag;
    logic busy;
    logic dpd;
    logic mem_we;
    logic [ADDR_W-1:0] mem_addr;
    logic [7:0] mem_wdata;
  } spife_state_t;

  spife_state_t state_r;
  spife_state_t state_nxt;

  // Page buffer storage and its write port.
  logic [7:0] page_buf [256];
  logic buf_we;
  logic [7:0] buf_idx;
  logic [7:0] buf_data;

  // True when an address lies inside the block-protected upper region.
  function automatic logic is_prot(input logic [ADDR_W-1:0] a,
                                   input logic hi, input logic lo);
    logic p;
    p = 1'b0;
    unique case ({hi, lo})
      2'b00: p = 1'b0;
      2'b01: p = a[ADDR_W-1] & a[ADDR_W-2];
      2'b10: p = a[ADDR_W-1];
      2'b11: p = 1'b1;
    endcase
    return p;
  endfunction

  // Next-state logic for the whole sequencer.
  always_comb begin
    logic fall;
    logic rise_ck;
    logic desel;
    logic idle;
    logic [2:0] bits_c;
    logic [8:0] nb_c;
    logic [7:0] byte_c;
    logic [ADDR_W-1:0] sec_base;
    fall = 1'b0;
    rise_ck = 1'b0;
    desel = 1'b0;
    idle = 1'b0;
    bits_c = 3'h0;
    nb_c = 9'h000;
    byte_c = 8'h00;
    sec_base = '0;
    state_nxt = state_r;
    buf_we = 1'b0;
    buf_idx = state_r.ptr;
    buf_data = 8'h00;
    // Two-flop synchronisers and edge history.
    state_nxt.cs_s1 = chip_select_n_i;
    state_nxt.cs_s2 = state_r.cs_s1;
    state_nxt.cs_d = state_r.cs_s2;
    state_nxt.ck_s1 = serial_clk_i;
    state_nxt.ck_s2 = state_r.ck_s1;
    state_nxt.ck_d = state_r.ck_s2;
    state_nxt.si_s1 = serial_in_i;
    state_nxt.si_s2 = state_r.si_s1;
    state_nxt.mem_we = 1'b0;
    if (state_r.timer != 32'h0000_0000) begin
      state_nxt.timer = state_r.timer - 32'h0000_0001;
    end
    fall = state_r.cs_d & ~state_r.cs_s2;
    desel = state_r.cs_s2 & ~state_r.cs_d;
    rise_ck = ~state_r.cs_s2 & state_r.ck_s2 & ~state_r.ck_d;
    idle = (state_r.st == ST_IDLE) & ~state_r.dpd;
    bits_c = fall ? 3'h0 : state_r.bits;
    nb_c = fall ? 9'h000 : state_r.nbytes;
    if (fall) begin
      state_nxt.bits = 3'h0;
      state_nxt.nbytes = 9'h000;
    end
    // R25 shift on rise
    if (rise_ck) begin
      byte_c = {state_r.shift[6:0], state_r.si_s2};
      state_nxt.shift = byte_c;
      state_nxt.bits = bits_c + 3'h1;
      if (bits_c == 3'h7) begin
        if (nb_c != LEN_SAT) begin
          state_nxt.nbytes = nb_c + 9'h001;
        end
        if (nb_c == 9'h000) begin
          state_nxt.cmd = byte_c;
          // R06 fresh mask
          if (byte_c == OP_PROG && idle) begin
            state_nxt.valid = '0;
          end
        end else if (nb_c < LEN_ADDR) begin
          state_nxt.addr = {state_r.addr[ADDR_W-9:0], byte_c};
          if (nb_c == 9'h003) begin
            state_nxt.ptr = byte_c;
          end
        end else if (state_r.cmd == OP_PROG && idle && state_r.write_latch_flag) begin
          // R04 page wrap
          // R05 last bytes win
          buf_we = 1'b1;
          buf_data = byte_c;
          state_nxt.valid[state_r.ptr] = 1'b1;
          state_nxt.ptr = state_r.ptr + 8'h01;
        end
      end
    end
    // Command execution on select rise.
    if (desel && state_r.bits == 3'h0 && state_r.st == ST_IDLE) begin
      sec_base = state_r.addr & ~SEC_MASK;
      if (state_r.dpd) begin
        // R23 release only
        // R19 writes ignored
        if (state_r.cmd == OP_RDPD && state_r.nbytes == LEN_OPCODE) begin
          state_nxt.dpd = 1'b0;
        end
      end else begin
        unique case (state_r.cmd)
          OP_WREN: begin
            if (state_r.nbytes == LEN_OPCODE) begin
              state_nxt.write_latch_flag = 1'b1;
            end
          end
          OP_WRDI: begin
            if (state_r.nbytes == LEN_OPCODE) begin
              state_nxt.write_latch_flag = 1'b0;
            end
          end
          OP_PROG: begin
            // R07 byte boundary
            // R02 latch check
            // R09 protected page
            if (state_r.nbytes >= LEN_PROG_MIN && state_r.write_latch_flag &&
                !is_prot(state_r.addr, protect_bit_hi_i,
                         protect_bit_lo_i)) begin
              // R08 start program
              state_nxt.st = ST_PROG_RD;
              state_nxt.base = state_r.addr & ~PAGE_MASK;
              state_nxt.walk = '0;
              state_nxt.timer = PROG_LOAD;
              state_nxt.busy = 1'b1;
              state_nxt.write_latch_flag = 1'b0;
            end
          end
          OP_PERASE: begin
            // R12 exact length
            // R13 protected page
            if (state_r.nbytes == LEN_ADDR && state_r.write_latch_flag &&
                !is_prot(state_r.addr, protect_bit_hi_i,
                         protect_bit_lo_i)) begin
              state_nxt.st = ST_ERASE;
              state_nxt.base = state_r.addr & ~PAGE_MASK;
              state_nxt.last = PAGE_MASK;
              state_nxt.walk = '0;
              state_nxt.timer = PERASE_LOAD;
              state_nxt.busy = 1'b1;
              state_nxt.write_latch_flag = 1'b0;
            end
          end
          OP_SERASE: begin
            // R16 exact length
            // R17 sector protection
            if (state_r.nbytes == LEN_ADDR && state_r.write_latch_flag &&
                !is_prot(sec_base | SEC_MASK, protect_bit_hi_i,
                         protect_bit_lo_i)) begin
              state_nxt.st = ST_ERASE;
              state_nxt.base = sec_base;
              state_nxt.last = SEC_MASK;
              state_nxt.walk = '0;
              state_nxt.timer = SERASE_LOAD;
              state_nxt.busy = 1'b1;
              state_nxt.write_latch_flag = 1'b0;
            end
          end
          OP_DPD: begin
            // R21 one byte
            // R20 from standby
            if (state_r.nbytes == LEN_OPCODE) begin
              state_nxt.st = ST_DPD_WAIT;
              state_nxt.timer = DPD_LOAD;
            end
          end
          default: begin
          end
        endcase
      end
    end
    // Self-timed cycle; commands arriving now fall through ignored.
    // R14 R18 R22 reject while busy
    unique case (state_r.st)
      ST_IDLE: begin
      end
      ST_PROG_RD: begin
        if (state_r.valid[state_r.walk[7:0]]) begin
          state_nxt.mem_addr = state_r.base | state_r.walk;
          state_nxt.st = ST_PROG_WR;
        end else if (state_r.walk[7:0] == PAGE_LAST) begin
          state_nxt.st = ST_WAIT;
        end else begin
          state_nxt.walk = state_r.walk + ADDR_W'(1);
        end
      end
      ST_PROG_WR: begin
        // R01 clear bits only
        state_nxt.mem_we = 1'b1;
        state_nxt.mem_wdata = mem_rdata_i & page_buf[state_r.walk[7:0]];
        if (state_r.walk[7:0] == PAGE_LAST) begin
          state_nxt.st = ST_WAIT;
        end else begin
          state_nxt.walk = state_r.walk + ADDR_W'(1);
          state_nxt.st = ST_PROG_RD;
        end
      end
      ST_ERASE: begin
        // R10 R15 fill erased
        state_nxt.mem_we = 1'b1;
        state_nxt.mem_addr = state_r.base | state_r.walk;
        state_nxt.mem_wdata = ERASED_BYTE;
        if (state_r.walk == state_r.last) begin
          state_nxt.st = ST_WAIT;
        end else begin
          state_nxt.walk = state_r.walk + ADDR_W'(1);
        end
      end
      ST_WAIT: begin
        // R24 internal clear
        if (state_r.timer == 32'h0000_0000) begin
          state_nxt.busy = 1'b0;
          state_nxt.st = ST_IDLE;
        end
      end
      ST_DPD_WAIT: begin
        if (state_r.timer == 32'h0000_0000) begin
          state_nxt.dpd = 1'b1;
          state_nxt.st = ST_IDLE;
        end
      end
      default: begin
        state_nxt.st = ST_IDLE;
        state_nxt.busy = 1'b0;
      end
    endcase
  end

  // State register; select idles high and serial clock low after reset.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= '0;
      state_r.cs_s1 <= 1'b1;
      state_r.cs_s2 <= 1'b1;
      state_r.cs_d <= 1'b1;
      state_r.st <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Page buffer storage, no reset needed behind the valid mask.
  always_ff @(posedge sys_clk_i) begin
    if (buf_we) begin
      page_buf[buf_idx] <= buf_data;
    end
  end

  assign busy_flag_o = state_r.busy;
  assign write_latch_flag_o = state_r.write_latch_flag;
  assign deep_pd_o = state_r.dpd;
  assign mem_we_o = state_r.mem_we;
  assign mem_addr_o = state_r.mem_addr;
  assign mem_wdata_o = state_r.mem_wdata;

endmodule // spife_core

// ==== hdl/spife_pkg.sv ====
// Shared constants for the serial flash program, erase and power-down core.
// Assumes a 200 MHz system clock; all times are converted from microseconds.
package spife_pkg;

  // Command opcodes, most significant bit shifted in first.
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_PERASE = 8'hDB;
  localparam logic [7:0] OP_SERASE = 8'hD8;
  localparam logic [7:0] OP_DPD = 8'hB9;
  localparam logic [7:0] OP_RDPD = 8'hAB;

  // Frame lengths in bytes for each command kind.
  localparam logic [8:0] LEN_OPCODE = 9'h001;
  localparam logic [8:0] LEN_ADDR = 9'h004;
  localparam logic [8:0] LEN_PROG_MIN = 9'h005;
  localparam logic [8:0] LEN_SAT = 9'h1FF;

  // Page geometry.
  localparam logic [7:0] PAGE_LAST = 8'hFF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // Self-timed cycle lengths.
  localparam int CLK_MHZ = 200;
  localparam int PROG_TIME_US = 800;
  localparam int PAGE_ERASE_TIME_US = 10000;
  localparam int SECTOR_ERASE_TIME_US = 1000000;
  localparam int DPD_ENTRY_TIME_US = 3;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam int PAGE_ERASE_CYCLES = PAGE_ERASE_TIME_US * CLK_MHZ;
  localparam int SECTOR_ERASE_CYCLES = SECTOR_ERASE_TIME_US * CLK_MHZ;
  localparam logic [31:0] DPD_CYCLES = 32'(DPD_ENTRY_TIME_US * CLK_MHZ);

  // Sector size in bytes.
  localparam int SECTOR_BYTES = 65536;

  // Control sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PROG_RD = 3'b001,
    ST_PROG_WR = 3'b010,
    ST_ERASE = 3'b011,
    ST_WAIT = 3'b100,
    ST_DPD_WAIT = 3'b101
  } spife_st_t;

endpackage

// ==== testbench/spife_core_sva.sv ====
// Assertions on the ports of the serial flash command core.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/1ps
module spife_core_sva (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic chip_select_n_i,
  input wire logic protect_bit_hi_i,
  input wire logic protect_bit_lo_i,
  input wire logic busy_flag_o,
  input wire logic write_latch_flag_o,
  input wire logic deep_pd_o,
  input wire logic mem_we_o,
  input wire logic [7:0] mem_wdata_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Busy, latch, select, protection and erase-data relations.
  AST_WE_BUSY: assert property (mem_we_o |-> busy_flag_o)
    else $error("array write outside a busy cycle");
  AST_WEL_CLR: assert property ($rose(busy_flag_o) |->
    !write_latch_flag_o)
    else $error("latch still set in busy cycle");
  AST_NEED_WEL: assert property ($rose(busy_flag_o) |->
    $past(write_latch_flag_o))
    else $error("cycle started without latch");
  AST_CS_HIGH: assert property ($rose(busy_flag_o) |->
    $past(chip_select_n_i) && $past(chip_select_n_i, 2))
    else $error("cycle started with select low");
  AST_ALL_PROT: assert property ($rose(busy_flag_o) |->
    !($past(protect_bit_hi_i) && $past(protect_bit_lo_i)))
    else $error("cycle started with all protected");
  AST_DPD_IDLE: assert property (deep_pd_o |-> !busy_flag_o)
    else $error("busy while powered down");
  AST_ERASE_FF: assert property (mem_we_o && $past(mem_we_o) |->
    mem_wdata_o == 8'hFF)
    else $error("erase write not FF");
  AST_BUSY_MIN: assert property ($rose(busy_flag_o) |=>
    busy_flag_o[*8])
    else $error("busy too short");
endmodule // spife_core_sva

bind spife_core spife_core_sva spife_core_sva_i (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .chip_select_n_i(chip_select_n_i),
  .protect_bit_hi_i(protect_bit_hi_i), .protect_bit_lo_i(protect_bit_lo_i),
  .busy_flag_o(busy_flag_o), .write_latch_flag_o(write_latch_flag_o),
  .deep_pd_o(deep_pd_o), .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o));

// ==== testbench/spife_spi_host.sv ====
// Bus master model driving select, serial clock and data in mode 0.
// Assumes a 5 ns system clock; one link bit takes 33 system clocks.
`timescale 1ns/1ps
module spife_spi_host (
  input wire logic sys_clk_i,
  output logic chip_select_n_o,
  output logic serial_clk_o,
  output logic serial_in_o
);
  // Idle levels at time zero.
  initial begin
    chip_select_n_o = 1'b1;
    serial_clk_o = 1'b0;
    serial_in_o = 1'b0;
  end
  task automatic bit_out(input logic v);
    @(posedge sys_clk_i) serial_in_o <= v;
    repeat (16) @(posedge sys_clk_i);
    serial_clk_o <= 1'b1;
    repeat (16) @(posedge sys_clk_i);
    serial_clk_o <= 1'b0;
  endtask
  task automatic frame(input logic [7:0] q[$], input int extra);
    @(posedge sys_clk_i) chip_select_n_o <= 1'b0;
    foreach (q[i]) for (int k = 7; k >= 0; k--) bit_out(q[i][k]);
    for (int k = 0; k < extra; k++) bit_out(1'b1);
    repeat (16) @(posedge sys_clk_i);
    chip_select_n_o <= 1'b1;
    // Released data line shows the inverse so stale bits are not trusted.
    serial_in_o <= ~serial_in_o;
    repeat (8) @(posedge sys_clk_i);
  endtask
endmodule // spife_spi_host

// ==== testbench/test_spi_flash_program_erase_powerdown.sv ====
// Self-checking bench for the serial flash command core.
// Assumes the host model for the link and a 64 KiB array model here.
`timescale 1ns/1ps
module test_spi_flash_program_erase_powerdown;
  import spife_pkg::*;
  localparam int PROG_T = 300;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic bp_hi = 1'b0;
  logic bp_lo = 1'b0;
  wire logic cs_n, sclk, sdi, busy, write_latch_flag, dpd, we;
  wire logic [23:0] addr;
  wire logic [7:0] wdata;
  logic [7:0] mem [0:65535];
  wire logic [7:0] rdata = mem[addr[15:0]];
  int num_errors = 0;
  int total_checks = 0;
  // Clock and array write port.
  initial forever #2.5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) if (we) mem[addr[15:0]] <= wdata;
  spife_core #(.PROG_CYC(PROG_T), .PERASE_CYC(600), .SERASE_CYC(2000),
    .SECTOR_SIZE(1024)) spife_core_i (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .chip_select_n_i(cs_n),
    .serial_clk_i(sclk), .serial_in_i(sdi), .protect_bit_hi_i(bp_hi),
    .protect_bit_lo_i(bp_lo), .mem_rdata_i(rdata), .busy_flag_o(busy),
    .write_latch_flag_o(write_latch_flag), .deep_pd_o(dpd), .mem_we_o(we),
    .mem_addr_o(addr), .mem_wdata_o(wdata));
  spife_spi_host spife_spi_host_i (.sys_clk_i(sys_clk_i),
    .chip_select_n_o(cs_n), .serial_clk_o(sclk), .serial_in_o(sdi));
  // Compares and counts.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic send(input logic [7:0] q[$], input int extra);
    spife_spi_host_i.frame(q, extra);
  endtask
  task automatic wait_idle(output int n);
    n = 0;
    while (busy === 1'b1 && n < 5000) begin
      @(posedge sys_clk_i);
      n++;
    end
    // A cycle that never ends is counted as a mismatch here.
    check(busy, 1'b0);
  endtask
  task automatic t_program();
    int n;
    mem[16'h00FE] = 8'hF0;
    send('{OP_WREN}, 0);
    check(write_latch_flag, 1'b1);
    send('{OP_PROG, 8'h00, 8'h00, 8'hFE, 8'hA5, 8'h3C, 8'h0F}, 0);
    check(busy, 1'b1);
    check(write_latch_flag, 1'b0);
    wait_idle(n);
    check(n >= PROG_T - 20 && n <= PROG_T + 10, 1'b1);
    check(mem[16'h00FE], 8'hA0);
    check(mem[16'h00FF], 8'h3C);
    check(mem[16'h0000], 8'h0F);
    check(mem[16'h0001], 8'hFF);
  endtask
  task automatic t_overflow();
    logic [7:0] q[$];
    int n;
    q = '{OP_PROG, 8'h00, 8'h01, 8'h00};
    for (int i = 0; i < 258; i++) q.push_back(i < 2 ? 8'h0F : 8'hF0);
    send('{OP_WREN}, 0);
    send(q, 0);
    wait_idle(n);
    check(mem[16'h0100], 8'hF0);
    check(mem[16'h0101], 8'hF0);
    check(mem[16'h01FF], 8'hF0);
  endtask
  task automatic t_refuse();
    send('{OP_WREN}, 0);
    send('{OP_PROG, 8'h00, 8'h02, 8'h00, 8'h00}, 1);
    check(busy, 1'b0);
    check(mem[16'h0200], 8'hFF);
    bp_hi <= 1'b1;
    bp_lo <= 1'b1;
    send('{OP_PERASE, 8'h00, 8'h00, 8'h00}, 0);
    check(busy, 1'b0);
    bp_lo <= 1'b0;
    send('{OP_PERASE, 8'h80, 8'h00, 8'h00}, 0);
    check(busy, 1'b0);
    bp_hi <= 1'b0;
    bp_lo <= 1'b1;
    send('{OP_SERASE, 8'hFF, 8'hFC, 8'h00}, 0);
    check(busy, 1'b0);
    send('{OP_PROG, 8'hFF, 8'hFF, 8'h00, 8'h00}, 0);
    check(busy, 1'b0);
    bp_lo <= 1'b0;
    check(write_latch_flag, 1'b1);
    send('{OP_WRDI}, 0);
    send('{OP_PERASE, 8'h00, 8'h00, 8'h00}, 0);
    check(busy, 1'b0);
  endtask
  task automatic t_erase();
    int n;
    mem[16'h0400] = 8'h00;
    mem[16'h07FF] = 8'h00;
    mem[16'h0800] = 8'h00;
    send('{OP_WREN}, 0);
    send('{OP_PERASE, 8'h00, 8'h01, 8'h80}, 0);
    wait_idle(n);
    check(mem[16'h0100], 8'hFF);
    check(mem[16'h01FF], 8'hFF);
    check(mem[16'h00FE], 8'hA0);
    send('{OP_WREN}, 0);
    send('{OP_SERASE, 8'h00, 8'h05, 8'h55}, 0);
    send('{OP_PERASE, 8'h00, 8'h08, 8'h00}, 0);
    send('{OP_DPD}, 0);
    wait_idle(n);
    repeat (700) @(posedge sys_clk_i);
    check(dpd, 1'b0);
    check(mem[16'h0800], 8'h00);
    check(mem[16'h0400], 8'hFF);
    check(mem[16'h07FF], 8'hFF);
  endtask
  task automatic t_deep_pd();
    send('{OP_DPD}, 0);
    repeat (550) @(posedge sys_clk_i);
    check(dpd, 1'b0);
    repeat (60) @(posedge sys_clk_i);
    check(dpd, 1'b1);
    send('{OP_WREN}, 0);
    check(write_latch_flag, 1'b0);
    send('{OP_RDPD}, 0);
    check(dpd, 1'b0);
    send('{OP_WREN}, 0);
    check(write_latch_flag, 1'b1);
  endtask
  // Main sequence after reset.
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    t_program();
    t_overflow();
    t_refuse();
    t_erase();
    t_deep_pd();
    test_done();
  end
  // Watchdog against a hung handshake.
  initial begin
    repeat (100000) @(posedge sys_clk_i);
    num_errors++;
    test_done();
  end
endmodule // test_spi_flash_program_erase_powerdown
